/* File: core/ptc_consts.vh */
`ifndef PTC_CONSTS_VH
`define PTC_CONSTS_VH

// ====================================================================
// Register indices (byte address is four times the index)
`define PTC_IDX_DIR_A 20'hee009
`define PTC_IDX_DIR_B 20'hee00a
`define PTC_IDX_MODE 20'hfffa0
`define PTC_IDX_TSEL 20'hfffa1
`define PTC_IDX_EN_B 20'hfffa2
`define PTC_IDX_EN_A 20'hfffa3
`define PTC_IDX_NXT_B 20'hfffa4
`define PTC_IDX_NXT_A 20'hfffa5
`define PTC_IDX_NXT_B_ALT 20'hfffa6
`define PTC_IDX_NXT_A_ALT 20'hfffa7
`define PTC_IDX_PDR_A 20'hfffd9
`define PTC_IDX_PDR_B 20'hfffda

// ====================================================================
// Reset values
`define PTC_RST_DIR 8'h00
`define PTC_RST_MODE 8'hf0
`define PTC_RST_TSEL 8'hff
`define PTC_RST_EN 8'h00
`define PTC_RST_NXT 8'h00
`define PTC_RST_PDR 8'h00

// ====================================================================
// Field layout
`define PTC_MODE_NOVL_W 4
`define PTC_NIBBLE_ONES 4'hf
`define PTC_BYTE_ONES 8'hff
`define PTC_SEL_CH0 2'b00
`define PTC_SEL_CH1 2'b01
`define PTC_CH2 2'b10

// ====================================================================
// Bus answers
`define PTC_RESP_OKAY 2'b00
`define PTC_RESP_SLVERR 2'b10

// ====================================================================
// Timing
`define PTC_CLK_MHZ 125
`define PTC_NOVL_NS 16
`define PTC_NOVL_CW 8

`endif

/* File: core/ptc_group.v */
`timescale 1ns/10ps
`default_nettype none
`include "ptc_consts.vh"

module ptc_group #(
   parameter [`PTC_NOVL_CW-1:0] MARGIN_CYC = 8'h02
) (
   // Clock and reset
   input wire sys_clk_i,
   input wire reset_i,
   input wire clear_i,
   // Trigger and control
   input wire trig_i,
   input wire novl_i,
   input wire [3:0] bit_en_i,
   input wire [3:0] next_i,
   input wire [3:0] cur_i,
   // Load to port data
   output wire [3:0] load_o,
   output wire [3:0] load_val_o
);

   reg [3:0] pend_r;
   reg [3:0] val_r;
   reg [`PTC_NOVL_CW-1:0] cnt_r;
   wire [3:0] rise;
   wire [3:0] imm;
   wire late;

   // ====================================================================
   // Immediate and delayed loads
   assign rise = bit_en_i & next_i & ~cur_i;
   assign imm = novl_i ? (bit_en_i & ~rise) : bit_en_i; // RULE4 RULE15
   assign late = (cnt_r == {{(`PTC_NOVL_CW-1){1'b0}}, 1'b1});
   assign load_o = trig_i ? imm : (late ? pend_r : 4'h0); // RULE10
   assign load_val_o = trig_i ? next_i : val_r;

   // ====================================================================
   // Non-overlap margin counter
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pend_r <= 4'h0;
         val_r <= 4'h0;
         cnt_r <= {`PTC_NOVL_CW{1'b0}};
      end else if (clear_i) begin
         pend_r <= 4'h0;
         val_r <= 4'h0;
         cnt_r <= {`PTC_NOVL_CW{1'b0}};
      end else if (trig_i && novl_i && (|rise)) begin
         pend_r <= rise; // RULE4
         val_r <= next_i;
         cnt_r <= MARGIN_CYC;
      end else if (cnt_r != {`PTC_NOVL_CW{1'b0}}) begin
         cnt_r <= cnt_r - {{(`PTC_NOVL_CW-1){1'b0}}, 1'b1};
         if (late) begin
            pend_r <= 4'h0;
         end
      end
   end

endmodule

`default_nettype wire

/* File: core/ptc_top.v */
// Overview of operation
// RULE1: Four 4-pin groups, each updated by its own trigger, all independent.
// RULE2: Sixteen pattern bits, each enabled or disabled on its own.
// RULE3: Each group picks its trigger from three timer compare-match strobes.
// RULE4: Non-overlap mode delays rising bits by a margin after falling ones.
// RULE5: Registers decode from the lower 20 bits of the word index.
// RULE6: Port data bits enabled for pattern output ignore software writes.
// RULE7: Shared trigger: lower next pattern is one byte; alternate reads ones.
// RULE8: Split triggers: group 1 high nibble first, group 0 low nibble alternate.
// RULE9: Upper next pattern uses the same scheme for groups 2 and 3.
// RULE10: Selected compare match copies group next bits into port data.
// RULE11: Next pattern clears on reset and hardware standby only.
// RULE12: Software sets direction bits of every pin used as pattern output.
// RULE13: Direction registers are 8-bit, write-only, reset to zero.
// RULE14: Port A carries outputs 0 to 7, port B outputs 8 to 15.
// RULE15: Disabled bits are not transferred on the trigger; enabled bits are.
// RULE16: Select 00 channel 0, 01 channel 1, 1x channel 2; reset all ones.
// RULE17: Each pin is driven from its port data bit when direction is 1.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "ptc_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module ptc_top #(
   parameter ADDR_W = 22
) (
   // Clock and reset
   input wire sys_clk_i,
   input wire reset_i,
   input wire hw_standby_i,
   // Timer compare-match strobes
   input wire [2:0] cmp_match_i,
   // AXI4-Lite write address
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // Pattern pins
   output wire [15:0] pattern_out_pin_o,
   output wire [15:0] pattern_out_oe_o
);

   localparam integer NOVL_INT = (`PTC_NOVL_NS * `PTC_CLK_MHZ + 999) / 1000;
   localparam [`PTC_NOVL_CW-1:0] NOVL_CYC = NOVL_INT[`PTC_NOVL_CW-1:0];
   localparam [7:0] MODE_RST = `PTC_RST_MODE;

   // ====================================================================
   // Registers
   reg [7:0] dir_a_r;
   reg [7:0] dir_b_r;
   reg [3:0] mode_r;
   reg [7:0] tsel_r;
   reg [7:0] en_a_r;
   reg [7:0] en_b_r;
   reg [7:0] nxt_a_r;
   reg [7:0] nxt_b_r;
   reg [7:0] pdr_a_r;
   reg [7:0] pdr_b_r;
   reg [7:0] pdr_a_nxt;
   reg [7:0] pdr_b_nxt;

   // Bus state
   reg aw_have_r;
   reg w_have_r;
   reg [ADDR_W-1:0] awaddr_r;
   reg [7:0] wdata_r;
   reg wstrb_r;
   reg bvalid_r;
   reg [1:0] bresp_r;
   reg rvalid_r;
   reg [7:0] rdata_r;
   reg [1:0] rresp_r;

   // Decode results
   reg [7:0] rd_val;
   reg rd_hit;
   reg wr_hit;

   wire [19:0] wr_idx;
   wire [19:0] rd_idx;
   wire wr_fire;
   wire wr_en;
   wire rd_fire;
   wire same_a;
   wire same_b;
   wire [3:0] trig;
   wire [15:0] en_all;
   wire [15:0] nxt_all;
   wire [15:0] cur_all;
   wire [15:0] ld_all;
   wire [15:0] ldv_all;

   // ====================================================================
   // Trigger selection
   function [1:0] chan_of;
      input [1:0] sel;
      begin
         if (sel[1]) begin
            chan_of = `PTC_CH2; // RULE16
         end else begin
            chan_of = sel;
         end
      end
   endfunction

   function pick;
      input [1:0] sel;
      input [2:0] cm;
      begin
         case (chan_of(sel))
            `PTC_SEL_CH0: pick = cm[0];
            `PTC_SEL_CH1: pick = cm[1];
            default: pick = cm[2];
         endcase
      end
   endfunction

   assign trig[0] = pick(tsel_r[1:0], cmp_match_i); // RULE3
   assign trig[1] = pick(tsel_r[3:2], cmp_match_i); // RULE3
   assign trig[2] = pick(tsel_r[5:4], cmp_match_i); // RULE3
   assign trig[3] = pick(tsel_r[7:6], cmp_match_i); // RULE3

   assign same_a = (chan_of(tsel_r[1:0]) == chan_of(tsel_r[3:2]));
   assign same_b = (chan_of(tsel_r[5:4]) == chan_of(tsel_r[7:6]));

   // ====================================================================
   // Group units
   assign en_all = {en_b_r, en_a_r}; // RULE2
   assign nxt_all = {nxt_b_r, nxt_a_r};
   assign cur_all = {pdr_b_r, pdr_a_r};

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : grp
         ptc_group #(
            .MARGIN_CYC(NOVL_CYC)
         ) u_grp ( // RULE1
            .sys_clk_i(sys_clk_i),
            .reset_i(reset_i),
            .clear_i(hw_standby_i),
            .trig_i(trig[g]),
            .novl_i(mode_r[g]),
            .bit_en_i(en_all[4*g+3:4*g]),
            .next_i(nxt_all[4*g+3:4*g]),
            .cur_i(cur_all[4*g+3:4*g]),
            .load_o(ld_all[4*g+3:4*g]),
            .load_val_o(ldv_all[4*g+3:4*g])
         );
      end
   endgenerate

   // ====================================================================
   // Bus handshakes
   assign s_axi_awready = ~aw_have_r & ~bvalid_r;
   assign s_axi_wready = ~w_have_r & ~bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = {24'h000000, rdata_r};
   assign s_axi_rresp = rresp_r;

   assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
   assign wr_en = wr_fire & wstrb_r;
   assign rd_fire = s_axi_arvalid & ~rvalid_r;
   assign wr_idx = awaddr_r[21:2]; // RULE5
   assign rd_idx = s_axi_araddr[21:2]; // RULE5

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= {ADDR_W{1'b0}};
         wdata_r <= 8'h00;
         wstrb_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `PTC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata[7:0];
            wstrb_r <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? `PTC_RESP_OKAY : `PTC_RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // ====================================================================
   // Read decode
   always @* begin
      rd_hit = 1'b1;
      rd_val = 8'h00;
      case (rd_idx)
         `PTC_IDX_DIR_A: rd_val = 8'h00; // RULE13
         `PTC_IDX_DIR_B: rd_val = 8'h00; // RULE13
         `PTC_IDX_MODE: rd_val = {`PTC_NIBBLE_ONES, mode_r};
         `PTC_IDX_TSEL: rd_val = tsel_r;
         `PTC_IDX_EN_B: rd_val = en_b_r;
         `PTC_IDX_EN_A: rd_val = en_a_r;
         `PTC_IDX_NXT_A: rd_val = same_a ? nxt_a_r : {nxt_a_r[7:4], `PTC_NIBBLE_ONES}; // RULE7 RULE8
         `PTC_IDX_NXT_A_ALT: rd_val = same_a ? `PTC_BYTE_ONES : {`PTC_NIBBLE_ONES, nxt_a_r[3:0]}; // RULE7 RULE8
         `PTC_IDX_NXT_B: rd_val = same_b ? nxt_b_r : {nxt_b_r[7:4], `PTC_NIBBLE_ONES}; // RULE9
         `PTC_IDX_NXT_B_ALT: rd_val = same_b ? `PTC_BYTE_ONES : {`PTC_NIBBLE_ONES, nxt_b_r[3:0]}; // RULE9
         `PTC_IDX_PDR_A: rd_val = pdr_a_r;
         `PTC_IDX_PDR_B: rd_val = pdr_b_r;
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rvalid_r <= 1'b0;
         rdata_r <= 8'h00;
         rresp_r <= `PTC_RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_val;
         rresp_r <= rd_hit ? `PTC_RESP_OKAY : `PTC_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ====================================================================
   // Write decode
   always @* begin
      case (wr_idx)
         `PTC_IDX_DIR_A, `PTC_IDX_DIR_B, `PTC_IDX_MODE, `PTC_IDX_TSEL,
         `PTC_IDX_EN_A, `PTC_IDX_EN_B, `PTC_IDX_NXT_A, `PTC_IDX_NXT_A_ALT,
         `PTC_IDX_NXT_B, `PTC_IDX_NXT_B_ALT, `PTC_IDX_PDR_A,
         `PTC_IDX_PDR_B: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // ====================================================================
   // Port data next value
   always @* begin
      pdr_a_nxt = pdr_a_r;
      pdr_b_nxt = pdr_b_r;
      if (wr_en && (wr_idx == `PTC_IDX_PDR_A)) begin
         pdr_a_nxt = (en_a_r & pdr_a_r) | (~en_a_r & wdata_r); // RULE6
      end
      if (wr_en && (wr_idx == `PTC_IDX_PDR_B)) begin
         pdr_b_nxt = (en_b_r & pdr_b_r) | (~en_b_r & wdata_r); // RULE6
      end
      pdr_a_nxt = (ld_all[7:0] & ldv_all[7:0]) | (~ld_all[7:0] & pdr_a_nxt); // RULE10 RULE15
      pdr_b_nxt = (ld_all[15:8] & ldv_all[15:8]) | (~ld_all[15:8] & pdr_b_nxt); // RULE10 RULE15
   end

   // ====================================================================
   // Register file
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         dir_a_r <= `PTC_RST_DIR; // RULE13
         dir_b_r <= `PTC_RST_DIR;
         mode_r <= MODE_RST[3:0];
         tsel_r <= `PTC_RST_TSEL; // RULE16
         en_a_r <= `PTC_RST_EN;
         en_b_r <= `PTC_RST_EN;
         nxt_a_r <= `PTC_RST_NXT; // RULE11
         nxt_b_r <= `PTC_RST_NXT;
         pdr_a_r <= `PTC_RST_PDR;
         pdr_b_r <= `PTC_RST_PDR;
      end else if (hw_standby_i) begin
         dir_a_r <= `PTC_RST_DIR;
         dir_b_r <= `PTC_RST_DIR;
         mode_r <= MODE_RST[3:0];
         tsel_r <= `PTC_RST_TSEL;
         en_a_r <= `PTC_RST_EN;
         en_b_r <= `PTC_RST_EN;
         nxt_a_r <= `PTC_RST_NXT; // RULE11
         nxt_b_r <= `PTC_RST_NXT;
         pdr_a_r <= `PTC_RST_PDR;
         pdr_b_r <= `PTC_RST_PDR;
      end else begin
         pdr_a_r <= pdr_a_nxt;
         pdr_b_r <= pdr_b_nxt;
         if (wr_en) begin
            case (wr_idx)
               `PTC_IDX_DIR_A: dir_a_r <= wdata_r; // RULE13
               `PTC_IDX_DIR_B: dir_b_r <= wdata_r; // RULE13
               `PTC_IDX_MODE: mode_r <= wdata_r[3:0];
               `PTC_IDX_TSEL: tsel_r <= wdata_r;
               `PTC_IDX_EN_A: en_a_r <= wdata_r; // RULE2
               `PTC_IDX_EN_B: en_b_r <= wdata_r;
               `PTC_IDX_NXT_A: begin
                  if (same_a) begin
                     nxt_a_r <= wdata_r; // RULE7
                  end else begin
                     nxt_a_r[7:4] <= wdata_r[7:4]; // RULE8
                  end
               end
               `PTC_IDX_NXT_A_ALT: begin
                  if (!same_a) begin
                     nxt_a_r[3:0] <= wdata_r[3:0]; // RULE8
                  end
               end
               `PTC_IDX_NXT_B: begin
                  if (same_b) begin
                     nxt_b_r <= wdata_r; // RULE9
                  end else begin
                     nxt_b_r[7:4] <= wdata_r[7:4]; // RULE9
                  end
               end
               `PTC_IDX_NXT_B_ALT: begin
                  if (!same_b) begin
                     nxt_b_r[3:0] <= wdata_r[3:0]; // RULE9
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ====================================================================
   // Pins
   assign pattern_out_pin_o = {pdr_b_r, pdr_a_r}; // RULE14 RULE17
   assign pattern_out_oe_o = {dir_b_r, dir_a_r}; // RULE12 RULE17

endmodule

`default_nettype wire

/* File: sim/ptc_props.sv */
`timescale 1ns/10ps
`default_nettype none
module ptc_props (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic hw_standby_i,
   input wire logic [2:0] cmp_match_i,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pattern pins
   input wire logic [15:0] pattern_out_pin_o,
   input wire logic [15:0] pattern_out_oe_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   logic [3:0] quiet_r;
   // ====================
   // Cycles since anything that may move a pin
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i)
         quiet_r <= 4'h0;
      else if (hw_standby_i || cmp_match_i != 3'h0 || s_axi_bvalid || s_axi_awvalid)
         quiet_r <= 4'h0;
      else if (quiet_r != 4'hf)
         quiet_r <= quiet_r + 4'h1;
   end
   // ====================
   // Checks
   AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response missing");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response missing");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
   AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during response");
   AST_R_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data above bit 7");
   AST_PIN_QUIET: assert property (quiet_r >= 4'h6 |-> $stable(pattern_out_pin_o))
      else $error("pin moved without cause");
   AST_OE_CAUSE: assert property ($changed(pattern_out_oe_o)
      |-> $rose(s_axi_bvalid) || $past(hw_standby_i)) else $error("enable moved without cause");
   AST_STANDBY: assert property (hw_standby_i
      |=> pattern_out_pin_o == 16'h0 && pattern_out_oe_o == 16'h0) else $error("standby kept pins");
   COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
   COV_TRIG: cover property (cmp_match_i != 3'h0 ##1 $changed(pattern_out_pin_o));
   COV_STBY: cover property (hw_standby_i && pattern_out_oe_o != 16'h0);
endmodule
bind ptc_top ptc_props u_props (.sys_clk_i, .reset_i, .hw_standby_i, .cmp_match_i,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pattern_out_pin_o, .pattern_out_oe_o);
`default_nettype wire

/* File: sim/ptc_tmr_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ptc_tmr_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Request from the bench
   input wire logic [2:0] go_i,
   input wire logic [3:0] dly_i,
   // Compare-match strobes
   output logic [2:0] cmp_o
);
   logic [3:0] cnt_r;
   logic [2:0] ch_r;
   // ====================
   // One-cycle strobe after a chosen delay
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= 4'h0;
         ch_r <= 3'h0;
         cmp_o <= 3'h0;
      end else if (go_i != 3'h0) begin
         cnt_r <= dly_i + 4'h1;
         ch_r <= go_i;
         cmp_o <= 3'h0;
      end else begin
         cnt_r <= (cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0;
         cmp_o <= (cnt_r == 4'h1) ? ch_r : 3'h0;
      end
   end
endmodule
`default_nettype wire

/* File: sim/timed_pattern_output_controller_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ptc_consts.vh"
module timed_pattern_output_controller_tb;
   logic clk, rst, stby, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [2:0] go, cmp;
   logic [3:0] dly;
   logic [21:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [15:0] pin, oe;
   int bad_count = 0;
   int checked = 0;
   localparam logic [1:0] OK = `PTC_RESP_OKAY;
   localparam logic [1:0] ER = `PTC_RESP_SLVERR;
   ptc_top DUT (.sys_clk_i(clk), .reset_i(rst), .hw_standby_i(stby), .cmp_match_i(cmp),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pattern_out_pin_o(pin), .pattern_out_oe_o(oe));
   ptc_tmr_model TMR (.clk_i(clk), .rst_i(rst), .go_i(go), .dly_i(dly), .cmp_o(cmp));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ====================
   // Shared tasks
   task report_and_stop();
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [19:0] idx, input logic [7:0] d, input logic [1:0] er);
      @(posedge clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            chk({30'h0, bresp}, {30'h0, er});
            bready <= 1'b0;
         end
      end while (bready);
   endtask
   task rd(input logic [19:0] idx, input logic [7:0] ed, input logic [1:0] er);
      @(posedge clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            chk(rdata, {24'h0, ed});
            chk({30'h0, rresp}, {30'h0, er});
            rready <= 1'b0;
         end
      end while (rready);
   endtask
   task fire(input logic [2:0] ch, input logic [3:0] d, input logic [15:0] exp);
      @(posedge clk);
      go <= ch;
      dly <= d;
      @(posedge clk);
      go <= 3'h0;
      while (cmp == 3'h0) @(posedge clk);
      @(posedge clk);
      #1;
      chk({16'h0, pin}, {16'h0, exp});
   endtask
   // ====================
   // Scenarios
   task s_reset_values();
      rd(`PTC_IDX_MODE, 8'hf0, OK);
      rd(`PTC_IDX_TSEL, 8'hff, OK);
      rd(`PTC_IDX_EN_A, 8'h00, OK);
      rd(`PTC_IDX_EN_B, 8'h00, OK);
      rd(`PTC_IDX_NXT_A, 8'h00, OK);
      rd(`PTC_IDX_NXT_B, 8'h00, OK);
      rd(`PTC_IDX_PDR_A, 8'h00, OK);
      rd(`PTC_IDX_PDR_B, 8'h00, OK);
      rd(20'h00123, 8'h00, ER);
      wr(20'h00123, 8'h55, ER);
      chk({16'h0, oe}, 32'h0);
   endtask
   task s_direction();
      wr(`PTC_IDX_DIR_A, 8'ha5, OK);
      wr(`PTC_IDX_DIR_B, 8'h3c, OK);
      chk({16'h0, oe}, 32'h3ca5);
      rd(`PTC_IDX_DIR_A, 8'h00, OK);
      wr(`PTC_IDX_DIR_A, 8'hff, OK);
      wr(`PTC_IDX_DIR_B, 8'hff, OK);
      chk({16'h0, oe}, 32'hffff);
   endtask
   task s_shared();
      wr(`PTC_IDX_NXT_A, 8'h5a, OK);
      rd(`PTC_IDX_NXT_A, 8'h5a, OK);
      wr(`PTC_IDX_NXT_A_ALT, 8'h00, OK);
      rd(`PTC_IDX_NXT_A_ALT, 8'hff, OK);
      wr(`PTC_IDX_NXT_B, 8'hc3, OK);
      rd(`PTC_IDX_NXT_B_ALT, 8'hff, OK);
      wr(`PTC_IDX_EN_A, 8'hf0, OK);
      wr(`PTC_IDX_EN_B, 8'h0f, OK);
      wr(`PTC_IDX_PDR_A, 8'hff, OK);
      rd(`PTC_IDX_PDR_A, 8'h0f, OK);
      fire(3'h4, 4'h0, 16'h035f);
      rd(`PTC_IDX_PDR_A, 8'h5f, OK);
      fire(3'h1, 4'h3, 16'h035f);
   endtask
   task s_split();
      wr(`PTC_IDX_TSEL, 8'hd8, OK);
      rd(`PTC_IDX_TSEL, 8'hd8, OK);
      wr(`PTC_IDX_EN_A, 8'hff, OK);
      wr(`PTC_IDX_EN_B, 8'hff, OK);
      wr(`PTC_IDX_NXT_A, 8'h3c, OK);
      rd(`PTC_IDX_NXT_A, 8'h3f, OK);
      wr(`PTC_IDX_NXT_A_ALT, 8'hc9, OK);
      rd(`PTC_IDX_NXT_A_ALT, 8'hf9, OK);
      wr(`PTC_IDX_NXT_B, 8'h7e, OK);
      rd(`PTC_IDX_NXT_B, 8'h7f, OK);
      wr(`PTC_IDX_NXT_B_ALT, 8'h21, OK);
      rd(`PTC_IDX_NXT_B_ALT, 8'hf1, OK);
      fire(3'h1, 4'h0, 16'h0359);
      fire(3'h2, 4'h5, 16'h0159);
      fire(3'h4, 4'h0, 16'h7139);
   endtask
   task s_mode_standby();
      wr(`PTC_IDX_MODE, 8'h0f, OK);
      rd(`PTC_IDX_MODE, 8'hff, OK);
      wr(`PTC_IDX_NXT_A_ALT, 8'h06, OK);
      fire(3'h1, 4'h0, 16'h7130);
      @(posedge clk);
      #1;
      chk({16'h0, pin}, 32'h7136);
      @(posedge clk);
      stby <= 1'b1;
      @(posedge clk);
      stby <= 1'b0;
      @(posedge clk);
      #1;
      chk({pin, oe}, 32'h0);
      rd(`PTC_IDX_NXT_A, 8'h00, OK);
      rd(`PTC_IDX_TSEL, 8'hff, OK);
      rd(`PTC_IDX_MODE, 8'hf0, OK);
   endtask
   // ====================
   // Main sequence and watchdog
   initial begin
      rst = 1'b1;
      stby = 1'b0;
      go = 3'h0;
      dly = 4'h0;
      awaddr = 22'h0;
      araddr = 22'h0;
      wdata = 32'h0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      s_reset_values();
      s_direction();
      s_shared();
      s_split();
      s_mode_standby();
      report_and_stop();
   end
   // Tests need about 250 cycles; allow about eighty times that
   initial begin
      #160000;
      bad_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire
